/* File: smbus_byte_engine.sv */
// Purpose: SMBus byte data path and four-mode sequencer with AXI4-Lite
//          access to the control/status and serial data byte registers.
// Assumes: Open-drain lines resolved outside; inputs are asynchronous.
// Notes:   The serial data byte register is also the shift register.
// Behaviour
// - Bytes leave on the data line most significant bit first.
// - First received bit lands in the most significant bit.
// - Line data shifts in while a byte shifts out.
// - Lost arbitration turns the master into a slave receiver.
// - Data byte is eight bits, read/write, resetting to zero.
// - Data byte is not shifted from the line while the byte event is set.
// - Exactly one of four transmit/receive master/slave modes holds.
// - Master from generated START until STOP or lost arbitration.
// - Byte event: receivers before acknowledge, transmitters after it.
// - Master write sends START, address with write bit, data bytes.
// - Master transmitter without a new data byte becomes receiver.
// - Stop request makes the master send STOP and leave master mode.
// - Master read clocks slave bytes, event after each byte.
// - Acknowledge bit one returns ACK, zero returns NACK.
// - Data write in master receiver switches to master transmitter.
// - Uninhibited address reception enters slave receiver with event.
// - Address NACK silences slave events until the next START.
// - STOP ends slave receiver; data write switches to transmitter.
// - Unwritten slave transmitter becomes receiver; STOP ends it.
// - Byte event holds the clock line low until software clears it.
// - Acknowledge request set per received byte, cleared after ack.
`timescale 1ns/100ps
module smbus_byte_engine (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [smbus_pkg::AW-1:0] awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   input  wire logic [smbus_pkg::AW-1:0] araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   input  wire logic                    scl_i,
   output logic                         scl_o,
   output logic                         scl_oe,
   input  wire logic                    sda_i,
   output logic                         sda_o,
   output logic                         sda_oe,
   output smbus_pkg::mode_e             mode
);
   smbus_pkg::flags_s flags_q;
   smbus_pkg::flags_s wf;
   smbus_pkg::cfg_s   cfg_q;
   smbus_pkg::gen_e   gen_q;
   logic [7:0]        data_q;
   logic [3:0]        bit_q;
   logic [smbus_pkg::TMR_W-1:0] tmr_q;
   logic [smbus_pkg::AW-1:0]    awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_have_q, w_have_q;
   logic              slave_q, addr_q, first_q, busy_q, wrote_q;
   logic              gen_low_q, gen_sda_q, drv_sda_q;
   logic              scl_s, sda_s, scl_p, sda_p;
   logic              scl_rise, scl_fall, start_det, stop_det;
   logic              run, rise_ev, fall_ev, tmr_done;
   logic              aw_hs, w_hs, ar_hs, do_wr, aw_d, w_d, bv_d, rv_d;
   logic              wr_ctrl, wr_cfg, wr_data, si_go, go_gen;
   logic              byte_rx_end, byte_tx_end, ack_rise, arb_lost;
   logic              gen_start_done, gen_stop_done, rx_to_tx;

   function automatic logic mapped(input logic [smbus_pkg::AW-1:0] a);
      mapped = (a == smbus_pkg::CTRL_ADDR) || (a == smbus_pkg::DATA_ADDR);
   endfunction : mapped

   pin_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pins_a  ({scl_i, sda_i}),
      .pins_s  ({scl_s, sda_s})
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_p <= scl_s;
         sda_p <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_p;
   assign scl_fall  = ~scl_s & scl_p;
   assign start_det = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
   // Line edges are ignored while the byte event stalls the bus.
   assign run       = cfg_q.enable & ~flags_q.si;
   assign rise_ev   = scl_rise & run;
   assign fall_ev   = scl_fall & run;
   assign tmr_done  = (tmr_q == smbus_pkg::TMR_ZERO);

   // AXI4-Lite handshakes; address and data are taken in either order.
   assign aw_hs = awvalid & awready;
   assign w_hs  = wvalid & wready;
   assign ar_hs = arvalid & arready;
   assign do_wr = aw_have_q & w_have_q & ~bvalid;
   assign aw_d  = (aw_have_q | aw_hs) & ~do_wr;
   assign w_d   = (w_have_q | w_hs) & ~do_wr;
   assign bv_d  = do_wr | (bvalid & ~bready);
   assign rv_d  = ar_hs | (rvalid & ~rready);

   assign wf      = smbus_pkg::flags_s'(wdata_q[smbus_pkg::FLAGS_W-1:0]);
   assign wr_ctrl = do_wr & (awaddr_q == smbus_pkg::CTRL_ADDR) & wstrb_q[0];
   assign wr_cfg  = do_wr & (awaddr_q == smbus_pkg::CTRL_ADDR) & wstrb_q[1];
   assign wr_data = do_wr & (awaddr_q == smbus_pkg::DATA_ADDR) & wstrb_q[0];
   assign si_go   = wr_ctrl & flags_q.si & ~wf.si;
   assign go_gen  = flags_q.master & (wf.start_request | wf.stop_request);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= smbus_pkg::RESP_OKAY;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         if (aw_hs) begin
            awaddr_q <= awaddr;
         end
         if (w_hs) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (do_wr) begin
            bresp <= mapped(awaddr_q) ? smbus_pkg::RESP_OKAY
                                      : smbus_pkg::RESP_SLVERR;
         end
         aw_have_q <= aw_d;
         w_have_q  <= w_d;
         bvalid    <= bv_d;
         awready   <= ~aw_d & ~bv_d;
         wready    <= ~w_d & ~bv_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= smbus_pkg::RESP_OKAY;
      end else begin
         if (ar_hs) begin
            rresp <= mapped(araddr) ? smbus_pkg::RESP_OKAY
                                    : smbus_pkg::RESP_SLVERR;
            if (araddr == smbus_pkg::CTRL_ADDR) begin
               rdata <= {22'h0, cfg_q, flags_q};
            end else if (araddr == smbus_pkg::DATA_ADDR) begin
               rdata <= {24'h0, data_q};
            end else begin
               rdata <= '0;
            end
         end
         rvalid  <= rv_d;
         arready <= ~rv_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= '0;
      end else if (wr_cfg) begin
         cfg_q <= wdata_q[smbus_pkg::CFG_LSB +: smbus_pkg::CFG_W];
      end
   end

   // Byte-level events of the shifter.
   assign byte_rx_end = fall_ev & (bit_q == smbus_pkg::BIT_ACK)
                      & ~flags_q.txmode
                      & (flags_q.master | slave_q
                         | (addr_q & ~cfg_q.slave_inhibit));
   assign byte_tx_end = fall_ev & (bit_q == smbus_pkg::BIT_DONE)
                      & flags_q.txmode & (flags_q.master | slave_q);
   assign ack_rise    = rise_ev & (bit_q == smbus_pkg::BIT_ACK);
   assign arb_lost    = rise_ev & flags_q.master & flags_q.txmode
                      & (bit_q < smbus_pkg::BIT_ACK) & ~drv_sda_q & ~sda_s;
   assign rx_to_tx    = fall_ev & (bit_q == smbus_pkg::BIT_DONE)
                      & ~flags_q.txmode & wrote_q;
   assign gen_start_done = (gen_q == smbus_pkg::G_START) & tmr_done;
   assign gen_stop_done  = (gen_q == smbus_pkg::G_STOP) & ~gen_low_q
                         & scl_s & tmr_done;

   // Flags: hardware updates come last so that a set beats a clear.
   always_ff @(posedge aclk) begin
      if (!aresetn || !cfg_q.enable) begin
         flags_q <= '0;
      end else begin
         if (wr_ctrl) begin
            flags_q.start_request <= wf.start_request;
            flags_q.stop_request  <= wf.stop_request;
            flags_q.ack           <= wf.ack;
            flags_q.si            <= wf.si;
            if (si_go) begin
               flags_q.arblost <= 1'b0;
            end
         end
         if (si_go && flags_q.txmode && !go_gen) begin
            flags_q.txmode <= wrote_q;
         end
         if (rx_to_tx) begin
            flags_q.txmode <= 1'b1;
         end
         if (gen_start_done) begin
            flags_q.master <= 1'b1;
            flags_q.txmode <= 1'b1;
            flags_q.si     <= 1'b1;
         end
         if (arb_lost) begin
            flags_q.master  <= 1'b0;
            flags_q.txmode  <= 1'b0;
            flags_q.arblost <= 1'b1;
         end
         if (ack_rise) begin
            flags_q.ack_request_flag <= 1'b0;
            if (flags_q.txmode) begin
               flags_q.ack <= ~sda_s;
            end
         end
         if (byte_rx_end) begin
            flags_q.si               <= 1'b1;
            flags_q.ack_request_flag <= 1'b1;
            if (addr_q) begin
               flags_q.start_request <= 1'b1;
            end
         end
         if (byte_tx_end) begin
            flags_q.si <= 1'b1;
         end
         if (gen_stop_done) begin
            flags_q.master       <= 1'b0;
            flags_q.txmode       <= 1'b0;
            flags_q.stop_request <= 1'b0;
         end
         if (stop_det && slave_q) begin
            flags_q.stop_request <= 1'b1;
            flags_q.si           <= 1'b1;
            flags_q.txmode       <= 1'b0;
         end
      end
   end

   // Slave addressing state and bus occupancy.
   always_ff @(posedge aclk) begin
      if (!aresetn || !cfg_q.enable) begin
         slave_q <= 1'b0;
         addr_q  <= 1'b0;
         first_q <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         if (fall_ev && bit_q == smbus_pkg::BIT_ACK && addr_q) begin
            addr_q  <= 1'b0;
            slave_q <= ~cfg_q.slave_inhibit;
            first_q <= ~cfg_q.slave_inhibit;
         end
         if (si_go && first_q) begin
            first_q <= 1'b0;
            if (!wf.ack) begin
               slave_q <= 1'b0;
            end
         end
         if (arb_lost) begin
            addr_q <= 1'b1;
         end
         if (start_det) begin
            busy_q  <= 1'b1;
            addr_q  <= ~flags_q.master & (gen_q == smbus_pkg::G_IDLE);
            slave_q <= 1'b0;
            first_q <= 1'b0;
         end
         if (stop_det) begin
            busy_q  <= 1'b0;
            addr_q  <= 1'b0;
            slave_q <= 1'b0;
            first_q <= 1'b0;
         end
      end
   end

   // Shift register doubling as the serial data byte register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_q <= smbus_pkg::DATA_RESET;
         bit_q  <= smbus_pkg::BIT_ZERO;
      end else begin
         if (wr_data) begin
            data_q <= wdata_q[7:0];
         end
         if (!cfg_q.enable || gen_start_done || start_det) begin
            bit_q <= smbus_pkg::BIT_ZERO;
         end else if (rise_ev && bit_q < smbus_pkg::BIT_ACK) begin
            data_q <= {data_q[6:0], sda_s};
            bit_q  <= bit_q + smbus_pkg::BIT_FIRST;
         end else if (ack_rise) begin
            bit_q <= smbus_pkg::BIT_DONE;
         end else if (fall_ev && bit_q == smbus_pkg::BIT_DONE) begin
            bit_q <= smbus_pkg::BIT_ZERO;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !cfg_q.enable) begin
         wrote_q <= 1'b0;
      end else if (wr_data) begin
         wrote_q <= 1'b1;
      end else if (gen_start_done
                   || (fall_ev && bit_q == smbus_pkg::BIT_DONE)) begin
         wrote_q <= 1'b0;
      end
   end

   // Data line drive; high means the line is pulled low.
   always_ff @(posedge aclk) begin
      if (!aresetn || !cfg_q.enable || gen_stop_done) begin
         drv_sda_q <= 1'b0;
      end else if (gen_q != smbus_pkg::G_RUN
                   && gen_q != smbus_pkg::G_IDLE) begin
         drv_sda_q <= gen_sda_q;
      end else if (arb_lost) begin
         drv_sda_q <= 1'b0;
      end else if (si_go && flags_q.txmode && !go_gen) begin
         drv_sda_q <= wrote_q & ~data_q[7];
      end else if (si_go && flags_q.ack_request_flag) begin
         drv_sda_q <= wf.ack;
      end else if (fall_ev && flags_q.txmode
                   && bit_q >= smbus_pkg::BIT_FIRST
                   && bit_q <= smbus_pkg::BIT_LAST) begin
         drv_sda_q <= ~data_q[7];
      end else if (fall_ev && bit_q == smbus_pkg::BIT_ACK) begin
         drv_sda_q <= 1'b0;
      end else if (fall_ev && bit_q == smbus_pkg::BIT_DONE) begin
         drv_sda_q <= rx_to_tx & ~data_q[7];
      end
   end

   // Master clock, START, repeated START and STOP generator.
   always_ff @(posedge aclk) begin
      if (!aresetn || !cfg_q.enable) begin
         gen_q     <= smbus_pkg::G_IDLE;
         tmr_q     <= smbus_pkg::SCL_HALF;
         gen_low_q <= 1'b0;
         gen_sda_q <= 1'b0;
      end else begin
         case (gen_q)
            smbus_pkg::G_IDLE: begin
               gen_low_q <= 1'b0;
               tmr_q     <= smbus_pkg::SCL_HALF;
               if (flags_q.start_request && !flags_q.si && !busy_q
                   && !flags_q.master) begin
                  gen_q     <= smbus_pkg::G_START;
                  gen_sda_q <= 1'b1;
               end
            end
            smbus_pkg::G_START: begin
               if (tmr_done) begin
                  gen_low_q <= 1'b1;
                  tmr_q     <= smbus_pkg::SCL_HALF;
                  gen_q     <= smbus_pkg::G_RUN;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            smbus_pkg::G_RUN: begin
               if (!flags_q.master) begin
                  gen_q     <= smbus_pkg::G_IDLE;
                  gen_low_q <= 1'b0;
               end else if (flags_q.si) begin
                  gen_low_q <= 1'b1;
                  tmr_q     <= smbus_pkg::SCL_HALF;
               end else if (gen_low_q && bit_q == smbus_pkg::BIT_ZERO
                            && tmr_done && (flags_q.stop_request
                                            || flags_q.start_request)) begin
                  tmr_q     <= smbus_pkg::SCL_HALF;
                  gen_sda_q <= flags_q.stop_request;
                  gen_q     <= flags_q.stop_request ? smbus_pkg::G_STOP
                                                    : smbus_pkg::G_RSTART;
               end else if (gen_low_q) begin
                  if (tmr_done) begin
                     gen_low_q <= 1'b0;
                     tmr_q     <= smbus_pkg::SCL_HALF;
                  end else begin
                     tmr_q <= tmr_q - 1'b1;
                  end
               end else if (!scl_s) begin
                  tmr_q <= smbus_pkg::SCL_HALF;
               end else if (tmr_done) begin
                  gen_low_q <= 1'b1;
                  tmr_q     <= smbus_pkg::SCL_HALF;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            smbus_pkg::G_STOP, smbus_pkg::G_RSTART: begin
               if (gen_low_q) begin
                  if (tmr_done) begin
                     gen_low_q <= 1'b0;
                     tmr_q     <= smbus_pkg::SCL_HALF;
                  end else begin
                     tmr_q <= tmr_q - 1'b1;
                  end
               end else if (!scl_s) begin
                  tmr_q <= smbus_pkg::SCL_HALF;
               end else if (!tmr_done) begin
                  tmr_q <= tmr_q - 1'b1;
               end else if (gen_q == smbus_pkg::G_STOP) begin
                  gen_sda_q <= 1'b0;
                  gen_q     <= smbus_pkg::G_IDLE;
               end else begin
                  gen_sda_q <= 1'b1;
                  tmr_q     <= smbus_pkg::SCL_HALF;
                  gen_q     <= smbus_pkg::G_START;
               end
            end
            default: begin
               gen_q <= smbus_pkg::G_IDLE;
            end
         endcase
      end
   end

   // Pin and mode outputs, all registered.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_o  <= 1'b0;
         sda_o  <= 1'b0;
         mode   <= smbus_pkg::MODE_SLV_RX;
      end else begin
         scl_oe <= cfg_q.enable & (flags_q.si | gen_low_q);
         sda_oe <= drv_sda_q;
         scl_o  <= 1'b0;
         sda_o  <= 1'b0;
         mode   <= smbus_pkg::mode_e'({flags_q.master,
                                       flags_q.txmode});
      end
   end
endmodule : smbus_byte_engine

/* File: smbus_pkg.sv */
// Purpose: Shared constants and types for the SMBus byte engine.
// Assumes: 50 MHz aclk, AXI4-Lite register access with 32-bit data.
// Notes:   Register byte address is four times the register index.
package smbus_pkg;
   localparam int unsigned CLK_NS      = 20;
   localparam int unsigned SCL_HALF_NS = 2500;
   // Least half period of the generated clock, rounded up to whole cycles.
   localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int          TMR_W        = 12;
   localparam logic [TMR_W-1:0] SCL_HALF = TMR_W'(SCL_HALF_CYC);
   localparam logic [TMR_W-1:0] TMR_ZERO = '0;

   localparam int         AW         = 12;
   localparam logic [7:0] CTRL_IDX   = 8'hc0;
   localparam logic [7:0] DATA_IDX   = 8'hc2;
   localparam logic [AW-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
   localparam logic [AW-1:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int         FLAGS_W    = 8;
   localparam int         CFG_LSB    = 8;
   localparam int         CFG_W      = 2;
   localparam logic [1:0] PINS_IDLE  = 2'h3;

   // Bit counter: 0..7 data bits, 8 acknowledge bit, 9 acknowledge done.
   localparam logic [3:0] BIT_ZERO  = 4'h0;
   localparam logic [3:0] BIT_FIRST = 4'h1;
   localparam logic [3:0] BIT_LAST  = 4'h7;
   localparam logic [3:0] BIT_ACK   = 4'h8;
   localparam logic [3:0] BIT_DONE  = 4'h9;

   // Encoding follows {master, transmitting}.
   typedef enum logic [1:0] {
      MODE_SLV_RX,
      MODE_SLV_TX,
      MODE_MST_RX,
      MODE_MST_TX
   } mode_e;

   typedef enum logic [2:0] {
      G_IDLE,
      G_START,
      G_RUN,
      G_STOP,
      G_RSTART
   } gen_e;

   // Control and status flags, bit 7 down to bit 0.
   typedef struct packed {
      logic master;
      logic txmode;
      logic start_request;
      logic stop_request;
      logic ack_request_flag;
      logic arblost;
      logic ack;
      logic si;
   } flags_s;

   typedef struct packed {
      logic enable;
      logic slave_inhibit;
   } cfg_s;
endpackage : smbus_pkg

/* File: pin_sync.sv */
// Purpose: Two-stage synchroniser for the clock and data line inputs.
// Assumes: Lines idle high; reset is synchronous and active low.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/100ps
module pin_sync (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] pins_a,
   output logic      [1:0] pins_s
);
   logic [1:0] meta_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= smbus_pkg::PINS_IDLE;
         pins_s <= smbus_pkg::PINS_IDLE;
      end else begin
         meta_q <= pins_a;
         pins_s <= meta_q;
      end
   end
endmodule : pin_sync

/* File: smbus_monitor.sv */
// Purpose: Port checker for the SMBus byte engine.
// Assumes: Sees only the top module ports.
// Notes:   Bound to the engine at the foot of this file.
`timescale 1ns/100ps
module smbus_monitor (
   input wire logic                     aclk,
   input wire logic                     aresetn,
   input wire logic                     awvalid,
   input wire logic                     awready,
   input wire logic                     wvalid,
   input wire logic                     wready,
   input wire logic                     bvalid,
   input wire logic                     bready,
   input wire logic [smbus_pkg::AW-1:0] araddr,
   input wire logic                     arvalid,
   input wire logic                     arready,
   input wire logic [31:0]              rdata,
   input wire logic                     rvalid,
   input wire logic                     rready,
   input wire logic                     scl_oe,
   input wire logic                     sda_oe,
   input wire smbus_pkg::mode_e         mode
);
   logic [smbus_pkg::AW-1:0] ra_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      if (arvalid && arready) ra_q <= araddr;
   end
   chk_reset_idle: assert property ($rose(aresetn) |-> !scl_oe && !sda_oe
      && mode == smbus_pkg::MODE_SLV_RX) else $error("not idle after reset");
   chk_write_answer: assert property (awvalid && awready && wvalid && wready
      |-> ##2 bvalid) else $error("write answer late");
   chk_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   chk_read_hold: assert property (rvalid && !rready |=> rvalid
      && $stable(rdata)) else $error("read data not held");
   chk_ar_refuse: assert property (rvalid |-> !arready)
      else $error("read address taken while answer pending");
   chk_aw_refuse: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answer pending");
   chk_ready_back: assert property (bvalid && bready |=> !bvalid ##1
      awready && wready) else $error("write readies not restored");
   chk_data_upper: assert property (
      rvalid && ra_q == smbus_pkg::DATA_ADDR |-> rdata[31:8] == 24'h0)
      else $error("data byte upper bits set");
   cover property (mode == smbus_pkg::MODE_MST_TX);
   cover property (mode == smbus_pkg::MODE_MST_RX);
   cover property (rvalid && ra_q == smbus_pkg::DATA_ADDR);
endmodule : smbus_monitor
bind smbus_byte_engine smbus_monitor u_mon (.aclk, .aresetn, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .bready, .araddr, .arvalid,
   .arready, .rdata, .rvalid, .rready, .scl_oe, .sda_oe, .mode);

/* File: smbus_partner.sv */
// Purpose: Behavioural SMBus slave on the far side of the lines.
// Assumes: Lines are pulled up; the engine makes the clock.
// Notes:   Acknowledges every byte it receives; sends tx_byte when read.
`timescale 1ns/100ps
module smbus_partner (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [7:0] tx_byte,
   output logic            sda_pull,
   output logic [7:0]      rx_byte
);
   logic [3:0] cnt;
   logic [7:0] sh;
   logic       rd;
   logic       first;
   initial begin
      {cnt, sda_pull, rd, first} = {4'hf, 3'h0};
      rx_byte = 8'h00;
   end
   always @(negedge sda) if (scl) begin
      {cnt, rd, first} = {4'h0, 2'h1};
   end
   always @(posedge sda) if (scl) cnt = 4'hf;
   always @(posedge scl) if (cnt != 4'hf) begin
      // A master NACK after a sent byte ends the read.
      if (cnt == 4'h8 && rd && !first && sda) rd = 1'b0;
      sh = {sh[6:0], sda};
      cnt = cnt + 4'h1;
   end
   always @(negedge scl) if (cnt != 4'hf) begin
      if (cnt == 4'h8 && (first || !rd)) begin
         rx_byte = sh;
         if (first) rd = sh[0];
         sda_pull = 1'b1;
      end else if (cnt == 4'h9) begin
         {cnt, first} = {4'h0, 1'b0};
         sda_pull = rd && !tx_byte[7];
      end else sda_pull = rd && cnt < 4'h8 && !tx_byte[3'h7 - cnt[2:0]];
   end
endmodule : smbus_partner

/* File: test_smbus_data_and_transfer_modes.sv */
// Purpose: Register and transfer tests of the SMBus byte engine.
// Assumes: One partner slave at the far side of the lines.
// Notes:   Status is polled over the register bus.
`timescale 1ns/100ps
module test_smbus_data_and_transfer_modes;
   localparam logic [11:0] CA = smbus_pkg::CTRL_ADDR;
   localparam logic [11:0] DA = smbus_pkg::DATA_ADDR;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic scl_o, scl_oe, sda_o, sda_oe, sda_pull;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [7:0]  rx_byte;
   smbus_pkg::mode_e mode;
   int bad_count, cmp_count, cyc;
   wire scl = !scl_oe;
   wire sda = !(sda_oe || sda_pull);
   smbus_byte_engine u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .scl_i(scl),
      .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe, .mode);
   smbus_partner u_far (.scl, .sda, .tx_byte(8'h96), .sda_pull, .rx_byte);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw;
      {ta, tw} = 2'h0;
      @(posedge aclk);
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge aclk);
         {ta, tw} = {ta | awready, tw | wready};
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!(ta && tw));
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
   endtask : rd
   task automatic wait_si;
      do rd(CA, rv); while (rv[0] !== 1'b1);
   endtask : wait_si
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hf};
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(DA, rv); chk(rv, 32'h0);
      rd(CA, rv); chk(rv, 32'h0);
      rd(12'h004, rv); chk(32'(rresp), 32'(smbus_pkg::RESP_SLVERR));
      wr(DA, 32'ha5); rd(DA, rv); chk(rv, 32'ha5);
      $display("test registers done");
      wr(CA, 32'h200); wr(CA, 32'h220); wait_si();
      rd(CA, rv); chk(rv & 32'hfd, 32'he1);
      chk(32'(mode), 32'(smbus_pkg::MODE_MST_TX));
      wr(DA, 32'ha4); wr(CA, 32'h200); wait_si();
      chk(32'(rx_byte), 32'ha4);
      rd(DA, rv); chk(rv, 32'ha4);
      rd(CA, rv); chk(rv & 32'hff, 32'hc3);
      wr(DA, 32'h3c); wr(CA, 32'h200); wait_si();
      chk(32'(rx_byte), 32'h3c);
      $display("test master write done");
      wr(CA, 32'h220); wait_si();
      wr(DA, 32'ha5); wr(CA, 32'h200); wait_si();
      wr(CA, 32'h200); wait_si();
      rd(CA, rv); chk(rv & 32'hfd, 32'h89);
      chk(32'(mode), 32'(smbus_pkg::MODE_MST_RX));
      rd(DA, rv); chk(rv, 32'h96);
      wr(CA, 32'h210);
      do rd(CA, rv); while (rv[7] !== 1'b0);
      repeat (300) @(posedge aclk);
      chk(rv & 32'h10, 32'h0);
      chk({30'h0, scl, sda}, 32'h3);
      chk(32'(mode[1]), 32'h0);
      $display("test master read done");
      close_out();
   end
endmodule : test_smbus_data_and_transfer_modes
